/* File: amr_pkg.sv */
package amr_pkg;
  // Taskfile register indices on the device register port
  localparam logic [2:0] REG_DATA   = 3'h0;
  localparam logic [2:0] REG_ERRFT  = 3'h1;
  localparam logic [2:0] REG_SCNT   = 3'h2;
  localparam logic [2:0] REG_SNUM   = 3'h3;
  localparam logic [2:0] REG_CYLLO  = 3'h4;
  localparam logic [2:0] REG_CYLHI  = 3'h5;
  localparam logic [2:0] REG_DEVHD  = 3'h6;
  localparam logic [2:0] REG_STSCMD = 3'h7;
  // Opcodes
  localparam logic [7:0] OP_LOG_EXT   = 8'h2F;
  localparam logic [7:0] OP_LOG_DMA   = 8'h47;
  localparam logic [7:0] OP_MULT      = 8'hC4;
  localparam logic [7:0] OP_MULT_EXT  = 8'h29;
  // Status bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  // Error cause and control bit positions
  localparam int ER_CRC = 7;
  localparam int ER_UNC = 6;
  localparam int ER_IDN = 4;
  localparam int ER_ABT = 2;
  localparam int CTL_HOB = 7;
  // Sector geometry, counts and reset values
  localparam int         SECT_WORDS    = 256;
  localparam int         WADDR_W       = 8;
  localparam logic [16:0] CNT_EXT_ZERO = 17'h10000;
  localparam logic [16:0] CNT_STD_ZERO = 17'h00100;
  localparam logic [7:0]  ERR_RESET    = 8'h00;
  localparam logic [7:0]  DEV_RESET    = 8'hA0;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_XFER} amr_state_t;
  typedef struct packed {
    logic        log_sel;
    logic [47:0] lba;
  } amr_media_cmd_t;
endpackage

/* File: amr_sector_mem.sv */
`timescale 1ns/1ps
module amr_sector_mem (
  input  wire logic                         i_clk,
  input  wire logic                         i_we,
  input  wire logic [amr_pkg::WADDR_W-1:0]  i_waddr,
  input  wire logic [15:0]                  i_wdata,
  input  wire logic [amr_pkg::WADDR_W-1:0]  i_raddr,
  output logic      [15:0]                  o_rdata
);
  logic [15:0] mem_q [amr_pkg::SECT_WORDS];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end
endmodule // amr_sector_mem

/* File: amr_read_cmds.sv */
`timescale 1ns/1ps
// Summary of operation
// R1: Opcode 47h performs exactly the same log read as opcode 2Fh.
// R2: Opcode C4h fetches sectors from media then sends them to host.
// R3: Opcode 29h does the same using a 48-bit starting address.
// R4: Sector data leaves through the data register, one 16-bit word per read.
// R5: Multiple reads raise one interrupt per block of preset size, not per sector.
// R6: Extended sector count is previous byte 15:8 and current byte 7:0.
// R7: A zero extended sector count transfers 65,536 sectors.
// R8: 48-bit address assembled from current and previous address register bytes.
// R9: Unrecoverable error returns failing address; high bytes visible when HOB set.
// R10: Host writes previous byte before current, and opcode last.
// R11: Failure sets error status, clears busy, posts cause bits in error register.
module amr_read_cmds (
  input  wire logic                    i_clk,
  input  wire logic                    i_srst,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  input  wire logic [2:0]              i_reg_addr,
  input  wire logic [15:0]             i_reg_wdata,
  input  wire logic                    i_ctl_wr,
  input  wire logic [7:0]              i_ctl_wdata,
  input  wire logic [7:0]              i_block_size,
  input  wire logic                    i_media_valid,
  input  wire logic [15:0]             i_media_word,
  input  wire logic                    i_media_unc,
  input  wire logic                    i_media_idnf,
  input  wire logic                    i_link_crc_err,
  output logic      [15:0]             o_reg_rdata,
  output logic                         o_intrq,
  output logic                         o_media_req,
  output amr_pkg::amr_media_cmd_t      o_media_cmd
);
  amr_pkg::amr_state_t state_q;
  logic [7:0]  sc_cur_q, sc_prev_q, sn_cur_q, sn_prev_q;
  logic [7:0]  cl_cur_q, cl_prev_q, ch_cur_q, ch_prev_q;
  logic [7:0]  dev_q, err_q;
  logic        stat_err_q, hob_q, mult_q, ext_q;
  logic [16:0] sect_left_q;
  logic [7:0]  blk_cnt_q;
  logic [47:0] lba_q;
  logic [amr_pkg::WADDR_W-1:0] wptr_q, rptr_q;
  logic [15:0] mem_dout;

  // Decode of host accesses
  wire tf_wr    = i_reg_wr && (i_reg_addr != amr_pkg::REG_STSCMD) && (i_reg_addr != amr_pkg::REG_DATA);
  wire cmd_wr   = i_reg_wr && (i_reg_addr == amr_pkg::REG_STSCMD);
  wire accept   = cmd_wr && (state_q == amr_pkg::ST_IDLE);
  wire [7:0] op = i_reg_wdata[7:0];
  // R1 same log path
  wire op_log   = (op == amr_pkg::OP_LOG_EXT) || (op == amr_pkg::OP_LOG_DMA);
  wire op_mult  = (op == amr_pkg::OP_MULT) || (op == amr_pkg::OP_MULT_EXT);
  wire op_ext   = op_log || (op == amr_pkg::OP_MULT_EXT);
  wire bad_op   = !(op_log || op_mult) || (op_mult && (i_block_size == 8'h00));
  wire go       = accept && !bad_op;
  // R6 count assembly
  wire [15:0] cnt16   = {sc_prev_q, sc_cur_q};
  // R7 zero means 65536
  wire [16:0] cnt_ext = (cnt16 == 16'h0000) ? amr_pkg::CNT_EXT_ZERO : {1'b0, cnt16};
  wire [16:0] cnt_std = (sc_cur_q == 8'h00) ? amr_pkg::CNT_STD_ZERO : {9'h000, sc_cur_q};
  // R8 address assembly
  wire [47:0] lba48   = {ch_prev_q, cl_prev_q, sn_prev_q, ch_cur_q, cl_cur_q, sn_cur_q};
  wire [47:0] lba28   = {20'h00000, dev_q[3:0], ch_cur_q, cl_cur_q, sn_cur_q};
  wire [47:0] lba_log = {24'h000000, cl_prev_q, cl_cur_q, sn_cur_q};
  wire [47:0] lba_new = op_log ? lba_log : (op_ext ? lba48 : lba28);

  wire fetching   = state_q == amr_pkg::ST_FETCH;
  wire xfering    = state_q == amr_pkg::ST_XFER;
  wire media_fail = fetching && (i_media_unc || i_media_idnf);
  wire crc_fail   = xfering && i_link_crc_err;
  wire fail       = media_fail || crc_fail;
  wire wr_word    = fetching && i_media_valid && !media_fail;
  wire sect_full  = wr_word && (wptr_q == amr_pkg::WADDR_W'(amr_pkg::SECT_WORDS - 1));
  wire data_rd    = i_reg_rd && (i_reg_addr == amr_pkg::REG_DATA) && xfering && !crc_fail;
  wire sect_done  = data_rd && (rptr_q == amr_pkg::WADDR_W'(amr_pkg::SECT_WORDS - 1));
  wire last_sect  = sect_left_q == 17'h00001;
  wire sts_rd     = i_reg_rd && (i_reg_addr == amr_pkg::REG_STSCMD);
  // R5 interrupt only at block start
  wire blk_start  = !mult_q || (blk_cnt_q == 8'h00);
  wire irq_set    = (sect_full && blk_start) || fail || (accept && bad_op);
  wire [7:0] blk_nxt = blk_cnt_q + 8'h01;

  wire [7:0] status = {fetching, 1'b1, 1'b0, 1'b1, xfering, 1'b0, 1'b0, stat_err_q};
  wire [7:0] sel_sc = hob_q ? sc_prev_q : sc_cur_q;
  wire [7:0] sel_sn = hob_q ? sn_prev_q : sn_cur_q;
  wire [7:0] sel_cl = hob_q ? cl_prev_q : cl_cur_q;
  wire [7:0] sel_ch = hob_q ? ch_prev_q : ch_cur_q;
  wire [7:0] rd_byte = (i_reg_addr == amr_pkg::REG_ERRFT) ? err_q :
                       (i_reg_addr == amr_pkg::REG_SCNT)  ? sel_sc :
                       (i_reg_addr == amr_pkg::REG_SNUM)  ? sel_sn :
                       (i_reg_addr == amr_pkg::REG_CYLLO) ? sel_cl :
                       (i_reg_addr == amr_pkg::REG_CYLHI) ? sel_ch :
                       (i_reg_addr == amr_pkg::REG_DEVHD) ? dev_q : status;
  wire [15:0] rd_val = (i_reg_addr == amr_pkg::REG_DATA) ? (xfering ? mem_dout : 16'h0000) : {8'h00, rd_byte};

  amr_sector_mem u_mem (
    .i_clk   (i_clk),
    .i_we    (wr_word),
    .i_waddr (wptr_q),
    .i_wdata (i_media_word),
    .i_raddr (rptr_q),
    .o_rdata (mem_dout)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q <= amr_pkg::ST_IDLE;
    end else begin
      case (state_q)
        amr_pkg::ST_IDLE: begin
          if (go) state_q <= amr_pkg::ST_FETCH;
        end
        amr_pkg::ST_FETCH: begin
          if (media_fail) state_q <= amr_pkg::ST_IDLE;
          else if (sect_full) state_q <= amr_pkg::ST_XFER;
        end
        amr_pkg::ST_XFER: begin
          if (crc_fail || (sect_done && last_sect)) state_q <= amr_pkg::ST_IDLE;
          else if (sect_done) state_q <= amr_pkg::ST_FETCH;
        end
        default: state_q <= amr_pkg::ST_IDLE;
      endcase
    end
  end

  // Taskfile bytes: host write shifts current into previous
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      {sc_cur_q, sc_prev_q, sn_cur_q, sn_prev_q} <= 32'h00000000;
      {cl_cur_q, cl_prev_q, ch_cur_q, ch_prev_q} <= 32'h00000000;
      dev_q <= amr_pkg::DEV_RESET;
    end else if (media_fail) begin
      // R9 failing address returned
      {sn_prev_q, sn_cur_q} <= {lba_q[31:24], lba_q[7:0]};
      {cl_prev_q, cl_cur_q} <= {lba_q[39:32], lba_q[15:8]};
      {ch_prev_q, ch_cur_q} <= {lba_q[47:40], lba_q[23:16]};
    end else if (tf_wr) begin
      // R10 previous written first
      case (i_reg_addr)
        amr_pkg::REG_SCNT:  {sc_prev_q, sc_cur_q} <= {sc_cur_q, i_reg_wdata[7:0]};
        amr_pkg::REG_SNUM:  {sn_prev_q, sn_cur_q} <= {sn_cur_q, i_reg_wdata[7:0]};
        amr_pkg::REG_CYLLO: {cl_prev_q, cl_cur_q} <= {cl_cur_q, i_reg_wdata[7:0]};
        amr_pkg::REG_CYLHI: {ch_prev_q, ch_cur_q} <= {ch_cur_q, i_reg_wdata[7:0]};
        amr_pkg::REG_DEVHD: dev_q <= i_reg_wdata[7:0];
        default: dev_q <= dev_q;
      endcase
    end
  end

  // R9 high byte select
  always_ff @(posedge i_clk) begin
    if (i_srst) hob_q <= 1'b0;
    else if (i_ctl_wr) hob_q <= i_ctl_wdata[amr_pkg::CTL_HOB];
    else if (tf_wr) hob_q <= 1'b0;
  end

  // R11 error status and causes
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      err_q      <= amr_pkg::ERR_RESET;
      stat_err_q <= 1'b0;
    end else if (accept) begin
      err_q      <= bad_op ? (8'h01 << amr_pkg::ER_ABT) : amr_pkg::ERR_RESET;
      stat_err_q <= bad_op;
    end else if (fail) begin
      err_q[amr_pkg::ER_UNC] <= media_fail && i_media_unc;
      err_q[amr_pkg::ER_IDN] <= media_fail && !i_media_unc;
      err_q[amr_pkg::ER_CRC] <= crc_fail;
      err_q[amr_pkg::ER_ABT] <= crc_fail;
      stat_err_q             <= 1'b1;
    end
  end

  // Transfer bookkeeping
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sect_left_q <= 17'h00000;
      blk_cnt_q   <= 8'h00;
      lba_q       <= 48'h000000000000;
      mult_q      <= 1'b0;
      ext_q       <= 1'b0;
      wptr_q      <= '0;
      rptr_q      <= '0;
    end else if (go) begin
      sect_left_q <= op_ext ? cnt_ext : cnt_std;
      blk_cnt_q   <= 8'h00;
      lba_q       <= lba_new;
      mult_q      <= op_mult;
      ext_q       <= op_ext;
      wptr_q      <= '0;
      rptr_q      <= '0;
    end else begin
      if (wr_word) wptr_q <= wptr_q + 1'b1;
      // R4 one word per read
      if (data_rd) rptr_q <= rptr_q + 1'b1;
      if (sect_done) begin
        sect_left_q <= sect_left_q - 17'h00001;
        lba_q       <= lba_q + 48'h000000000001;
        blk_cnt_q   <= (blk_nxt == i_block_size) ? 8'h00 : blk_nxt;
      end
    end
  end

  // Outputs, each a flop; status read clears interrupt, set wins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_reg_rdata <= 16'h0000;
      o_intrq     <= 1'b0;
      o_media_req <= 1'b0;
      o_media_cmd <= '0;
    end else begin
      if (i_reg_rd) o_reg_rdata <= rd_val;
      o_intrq     <= irq_set || (o_intrq && !sts_rd);
      // R2 R3 sector fetch request
      o_media_req <= go || (sect_done && !last_sect);
      if (go) begin
        o_media_cmd.log_sel <= op_log;
        o_media_cmd.lba     <= lba_new;
      end else if (sect_done) begin
        o_media_cmd.lba     <= lba_q + 48'h000000000001;
      end
    end
  end

  // R2 media request
  req_on_go_a: assert property (@(posedge i_clk) disable iff (i_srst) // R2
    go |=> o_media_req && state_q == amr_pkg::ST_FETCH && o_media_cmd.lba == $past(lba_new))
    else $error("no media request after accepted read");
  // R8 address assembly
  lba48_map_a: assert property (@(posedge i_clk) disable iff (i_srst) // R8
    accept && op == amr_pkg::OP_MULT_EXT && !bad_op |=> o_media_cmd.lba == $past(lba48))
    else $error("48-bit address assembled wrongly");
  // R7 zero count
  zero_count_a: assert property (@(posedge i_clk) disable iff (i_srst) // R7
    go && op_ext && cnt16 == 16'h0000 |=> sect_left_q == amr_pkg::CNT_EXT_ZERO)
    else $error("zero extended count not 65536");
  // R6 count bytes
  count_bytes_a: assert property (@(posedge i_clk) disable iff (i_srst) // R6
    go && op_ext && cnt16 != 16'h0000 |=> sect_left_q[15:0] == $past({sc_prev_q, sc_cur_q}))
    else $error("extended count bytes misordered");
  // R1 log opcodes alike
  log_alike_a: assert property (@(posedge i_clk) disable iff (i_srst) // R1
    go && op == amr_pkg::OP_LOG_DMA |=> o_media_cmd.log_sel && ext_q && !mult_q)
    else $error("dma log read differs from log read");
  // R4 word stepping
  word_step_a: assert property (@(posedge i_clk) disable iff (i_srst) // R4
    data_rd && !sect_done |=> rptr_q == $past(rptr_q) + 8'h01 && xfering)
    else $error("data read did not step one word");
  // R5 block pacing
  block_irq_a: assert property (@(posedge i_clk) disable iff (i_srst) // R5
    sect_full && mult_q && blk_cnt_q != 8'h00 && !o_intrq |=> !o_intrq)
    else $error("interrupt raised inside a block");
  // R11 failure reporting
  fail_report_a: assert property (@(posedge i_clk) disable iff (i_srst) // R11
    fail |=> state_q == amr_pkg::ST_IDLE && stat_err_q && o_intrq && !status[amr_pkg::ST_BSY])
    else $error("failure not reported");
  // R9 failing address
  fail_lba_a: assert property (@(posedge i_clk) disable iff (i_srst) // R9
    media_fail |=> {ch_prev_q, cl_prev_q, sn_prev_q, ch_cur_q, cl_cur_q, sn_cur_q} == $past(lba_q))
    else $error("failing address not returned");
  // R11 bad command abort
  bad_cmd_abort_a: assert property (@(posedge i_clk) disable iff (i_srst) // R11
    accept && bad_op |=> err_q[amr_pkg::ER_ABT] && stat_err_q && state_q == amr_pkg::ST_IDLE)
    else $error("bad command not aborted");

  ext_read_c: cover property (@(posedge i_clk) disable iff (i_srst)
    go && op == amr_pkg::OP_MULT_EXT ##[1:1000] sect_done && last_sect);
  unc_err_c: cover property (@(posedge i_clk) disable iff (i_srst) media_fail && ext_q);
  block_c: cover property (@(posedge i_clk) disable iff (i_srst)
    sect_done && mult_q && blk_nxt == i_block_size && !last_sect);
endmodule // amr_read_cmds

/* File: amr_media_model.sv */
`timescale 1ns/1ps
module amr_media_model (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_req,
  input  wire logic [47:0] i_lba,
  input  wire logic [1:0]  i_fault,
  input  wire logic        i_slow,
  output logic             o_valid,
  output logic [15:0]      o_word,
  output logic             o_unc,
  output logic             o_idnf
);
  logic [8:0] cnt_q;
  logic [7:0] tag_q;
  logic       run_q;
  logic       tick_q;

  always_ff @(posedge i_clk) begin
    o_valid <= 1'b0;
    o_unc   <= 1'b0;
    o_idnf  <= 1'b0;
    // Released word lines toggle so stale data never looks valid
    o_word  <= ~o_word;
    tick_q  <= ~tick_q;
    if (i_srst) begin
      run_q  <= 1'b0;
      tick_q <= 1'b0;
      o_word <= 16'h0000;
    end else if (i_req) begin
      run_q <= 1'b1;
      cnt_q <= 9'h000;
      tag_q <= i_lba[7:0];
    end else if (run_q && (!i_slow || tick_q)) begin
      if (i_fault != 2'h0) begin
        run_q  <= 1'b0;
        o_unc  <= (i_fault == 2'h1);
        o_idnf <= (i_fault == 2'h2);
      end else begin
        o_valid <= 1'b1;
        o_word  <= {tag_q, cnt_q[7:0]};
        cnt_q   <= cnt_q + 9'h001;
        run_q   <= (cnt_q != 9'h0FF);
      end
    end
  end
endmodule // amr_media_model

/* File: test_amr_read_cmds.sv */
`timescale 1ns/1ps
module test_amr_read_cmds;
  typedef struct {
    logic [7:0]  op;
    logic [15:0] cnt;
    logic [47:0] tf;
    logic [3:0]  dev;
    logic [47:0] lba;
    logic        lg;
    int          nsec;
    int          nirq;
  } amr_row_t;
  logic                    i_clk, i_srst, reg_wr, reg_rd, ctl_wr, crc_err, slow, irq_q, clr_req;
  logic                    m_valid, m_unc, m_idnf, m_req, intrq;
  logic [2:0]              reg_addr;
  logic [15:0]             reg_wdata, rdata, m_word, v;
  logic [7:0]              ctl_wdata, bsize;
  logic [1:0]              fault;
  amr_pkg::amr_media_cmd_t m_cmd, first_cmd;
  amr_row_t                rows[4], r;
  int                      n_errors = 0, total_checks = 0, n_req = 0, n_irq = 0;

  amr_read_cmds u_amr_read_cmds (
    .i_clk(i_clk), .i_srst(i_srst), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_ctl_wr(ctl_wr), .i_ctl_wdata(ctl_wdata), .i_block_size(bsize),
    .i_media_valid(m_valid), .i_media_word(m_word), .i_media_unc(m_unc), .i_media_idnf(m_idnf),
    .i_link_crc_err(crc_err), .o_reg_rdata(rdata), .o_intrq(intrq), .o_media_req(m_req), .o_media_cmd(m_cmd));
  amr_media_model u_amr_media_model (
    .i_clk(i_clk), .i_srst(i_srst), .i_req(m_req), .i_lba(m_cmd.lba), .i_fault(fault), .i_slow(slow),
    .o_valid(m_valid), .o_word(m_word), .o_unc(m_unc), .o_idnf(m_idnf));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    if (m_req && n_req == 0) first_cmd <= m_cmd;
    // Counters cleared here only, so one process owns them
    if (clr_req) begin
      n_req <= 0;
      n_irq <= 0;
    end else begin
      if (m_req) n_req <= n_req + 1;
      if (intrq === 1'b1 && irq_q !== 1'b1) n_irq <= n_irq + 1;
    end
    irq_q <= intrq;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic clr();
    @(posedge i_clk);
    clr_req <= 1'b1;
    @(posedge i_clk);
    clr_req <= 1'b0;
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= {8'h00, d};
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic wctl(input logic [7:0] d);
    @(posedge i_clk);
    ctl_wr <= 1'b1;
    ctl_wdata <= d;
    @(posedge i_clk);
    ctl_wr <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [15:0] q);
    @(posedge i_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    @(posedge i_clk);
    #1 q = rdata;
  endtask

  task automatic issue(input amr_row_t t);
    wreg(amr_pkg::REG_SCNT, t.cnt[15:8]);
    wreg(amr_pkg::REG_SCNT, t.cnt[7:0]);
    for (int j = 0; j < 3; j++) begin
      wreg(3'(amr_pkg::REG_SNUM + j), t.tf[24+8*j +: 8]);
      wreg(3'(amr_pkg::REG_SNUM + j), t.tf[8*j +: 8]);
    end
    wreg(amr_pkg::REG_DEVHD, {4'hE, t.dev});
    wreg(amr_pkg::REG_STSCMD, t.op);
  endtask

  task automatic wait_drq();
    v = 16'h0000;
    for (int k = 0; k < 600 && v[3] !== 1'b1 && v[0] !== 1'b1; k++) rreg(amr_pkg::REG_STSCMD, v);
  endtask

  task automatic read_sector(input logic [7:0] tag, input logic cmp);
    for (int i = 0; i < amr_pkg::SECT_WORDS; i++) begin
      rreg(amr_pkg::REG_DATA, v);
      if (cmp) chk(v, {tag, i[7:0]}, "data word");
    end
  endtask

  task automatic chk_reset();
    chk(intrq, 1'b0, "irq after reset");
    rreg(amr_pkg::REG_STSCMD, v);
    chk(v[7:0], 8'h50, "status after reset");
    rreg(amr_pkg::REG_ERRFT, v);
    chk(v[7:0], 8'h00, "cause after reset");
    rreg(amr_pkg::REG_DEVHD, v);
    chk(v[7:0], 8'hA0, "dev after reset");
  endtask

  initial begin
    // About four times the expected run of some 10000 cycles
    #160000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    rows[0] = '{amr_pkg::OP_LOG_EXT, 16'h0001, 48'h001200003430, 4'h0, 48'h000000123430, 1'b1, 1, 1};
    rows[1] = '{amr_pkg::OP_LOG_DMA, 16'h0001, 48'h001200003430, 4'h0, 48'h000000123430, 1'b1, 1, 1};
    rows[2] = '{amr_pkg::OP_MULT, 16'h0001, 48'h000000332211, 4'h4, 48'h000004332211, 1'b0, 1, 1};
    rows[3] = '{amr_pkg::OP_MULT_EXT, 16'h0002, 48'h665544332211, 4'h0, 48'h665544332211, 1'b0, 2, 1};
    {reg_wr, reg_rd, ctl_wr, crc_err, slow, clr_req} = 6'h00;
    {reg_addr, reg_wdata, ctl_wdata, fault} = '0;
    bsize = 8'h02;
    i_srst = 1'b1;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    chk_reset();
    $display("reset done");
    foreach (rows[i]) begin
      @(posedge i_clk);
      slow <= i[0];
      clr();
      issue(rows[i]);
      for (int s = 0; s < rows[i].nsec; s++) begin
        wait_drq();
        read_sector(rows[i].lba[7:0], s == 0);
      end
      repeat (4) @(posedge i_clk);
      chk(first_cmd.lba, rows[i].lba, "start address");
      chk(first_cmd.log_sel, rows[i].lg, "log select");
      chk(n_req, rows[i].nsec, "sector count");
      chk(n_irq, rows[i].nirq, "irq per block");
      rreg(amr_pkg::REG_STSCMD, v);
      chk(v[7:0], 8'h50, "final status");
      $display("row %0d done", i);
    end
    for (int e = 1; e < 3; e++) begin
      clr();
      @(posedge i_clk);
      fault <= e[1:0];
      issue(rows[3]);
      repeat (20) @(posedge i_clk);
      fault <= 2'h0;
      rreg(amr_pkg::REG_ERRFT, v);
      chk(v[7:0], e == 1 ? 8'h40 : 8'h10, "fault cause");
      rreg(amr_pkg::REG_STSCMD, v);
      chk({v[7], v[0]}, 2'b01, "fault status");
      chk(n_irq, 1, "fault irq");
      for (int h = 0; h < 2; h++) begin
        for (int j = 0; j < 3; j++) begin
          rreg(3'(amr_pkg::REG_SNUM + j), v);
          chk(v[7:0], rows[3].lba[24*h+8*j +: 8], "failing address");
        end
        wctl(8'h80);
      end
      wctl(8'h00);
      $display("media fault %0d done", e);
    end
    for (int e = 0; e < 2; e++) begin
      clr();
      @(posedge i_clk);
      bsize <= e ? 8'h00 : 8'h02;
      wreg(amr_pkg::REG_STSCMD, e ? amr_pkg::OP_MULT : 8'h00);
      repeat (4) @(posedge i_clk);
      rreg(amr_pkg::REG_ERRFT, v);
      chk(v[7:0], 8'h04, "abort cause");
      rreg(amr_pkg::REG_STSCMD, v);
      chk({v[7], v[3], v[0]}, 3'b001, "abort status");
      chk(n_irq, 1, "abort irq");
      rreg(amr_pkg::REG_DATA, v);
      chk(v, 16'h0000, "data outside transfer");
      $display("abort %0d done", e);
    end
    bsize <= 8'h02;
    clr();
    issue(rows[2]);
    wait_drq();
    repeat (10) rreg(amr_pkg::REG_DATA, v);
    wreg(amr_pkg::REG_STSCMD, amr_pkg::OP_LOG_EXT);
    @(posedge i_clk);
    crc_err <= 1'b1;
    @(posedge i_clk);
    crc_err <= 1'b0;
    repeat (4) @(posedge i_clk);
    rreg(amr_pkg::REG_ERRFT, v);
    chk(v[7:0], 8'h84, "crc cause");
    chk(n_req, 1, "busy command ignored");
    chk(n_irq, 2, "crc irq");
    $display("crc abort done");
    clr();
    r = rows[3];
    r.cnt = 16'h0000;
    issue(r);
    repeat (2) begin
      wait_drq();
      read_sector(8'h00, 1'b0);
    end
    repeat (4) @(posedge i_clk);
    chk(n_req, 3, "zero count keeps going");
    chk(n_irq, 1, "one irq for two-sector block");
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    chk_reset();
    $display("zero count and reset done");
    report_and_stop();
  end
endmodule // test_amr_read_cmds
